// ===== time_stamp_regs.svh
// Constants of the network time stamp unit: timing counts and field widths.
// Assumes a 200 MHz module clock; included by its bare name.
`ifndef TIME_STAMP_REGS_SVH
`define TIME_STAMP_REGS_SVH

`define CLK_PERIOD_PS       5000
`define MICROSECOND_PS      1000000
`define CYCLES_PER_US       (`MICROSECOND_PS / `CLK_PERIOD_PS)
`define NET_SOC_DELAY_US    20
`define MIN_BUS_CYCLE_US    200
`define TIME_WIDTH          32

`endif

// ===== time_stamp_pkg.sv
// Types of the network time stamp unit.
// Assumes time_stamp_regs.svh supplies the numeric constants.
`include "time_stamp_regs.svh"
package time_stamp_pkg;
  typedef logic [`TIME_WIDTH-1:0] time_t;
  typedef enum logic [1:0] {
    SRC_NONE     = 2'b00,
    SRC_BACKPLANE = 2'b01,
    SRC_NETWORK  = 2'b10
  } time_source_t;
  typedef enum logic [1:0] {
    MEAS_IDLE    = 2'b00,
    MEAS_RUNNING = 2'b01,
    MEAS_DONE    = 2'b10
  } meas_state_t;
endpackage

// ===== time_base_if.sv
// Interface carrying the corrected time between the time stamp modules.
// Assumes one clock domain shared by all users.
`timescale 1ns/1ps
interface time_base_if;
  time_stamp_pkg::time_t now;
  logic                  valid;
  modport source (output now, output valid);
  modport sink   (input now, input valid);
endinterface

// ===== edge_capture.sv
// Captures corrected times of rising and optional falling edges of one input.
// Assumes the input is synchronous to clk and the time base is corrected.
`timescale 1ns/1ps
module edge_capture (
  input  wire logic          clk,
  input  wire logic          reset,
  time_base_if.sink          tb,
  input  wire logic          sig_in,
  input  wire logic          falling_enable,
  output logic               event_pulse,
  output time_stamp_pkg::time_t rise_time,
  output time_stamp_pkg::time_t fall_time,
  output time_stamp_pkg::time_t interval
);
  logic                  prev;
  logic                  next_prev;
  logic                  rose;
  logic                  fell;
  time_stamp_pkg::time_t last_time;
  time_stamp_pkg::time_t next_last_time;
  time_stamp_pkg::time_t next_rise_time;
  time_stamp_pkg::time_t next_fall_time;
  time_stamp_pkg::time_t next_interval;

  always_comb begin
    next_prev      = sig_in;
    rose           = tb.valid && sig_in && !prev;
    fell           = tb.valid && !sig_in && prev && falling_enable;
    next_rise_time = rise_time;
    next_fall_time = fall_time;
    next_interval  = interval;
    next_last_time = last_time;
    if (rose || fell) begin
      next_interval  = tb.now - last_time;
      next_last_time = tb.now;
    end
    if (rose) begin
      next_rise_time = tb.now;
    end
    if (fell) begin
      next_fall_time = tb.now;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prev        <= 1'b0;
      rise_time   <= 32'h0000_0000;
      fall_time   <= 32'h0000_0000;
      interval    <= 32'h0000_0000;
      last_time   <= 32'h0000_0000;
      event_pulse <= 1'b0;
    end else begin
      prev        <= next_prev;
      rise_time   <= next_rise_time;
      fall_time   <= next_fall_time;
      interval    <= next_interval;
      last_time   <= next_last_time;
      event_pulse <= rose || fell;
    end
  end
endmodule

// ===== edge_scheduler.sv
// Drives an output level change when the corrected time reaches a commanded time.
// Assumes commands lie in the future by at least one bus cycle.
`timescale 1ns/1ps
`include "time_stamp_regs.svh"
module edge_scheduler (
  input  wire logic          clk,
  input  wire logic          reset,
  time_base_if.sink          tb,
  input  wire logic          cmd_valid,
  input  wire logic          cmd_level,
  input  time_stamp_pkg::time_t cmd_time,
  output logic               cmd_ready,
  output logic               out_level,
  output logic               fired
);
  logic                  pending;
  logic                  next_pending;
  logic                  level_req;
  logic                  next_level_req;
  time_stamp_pkg::time_t due;
  time_stamp_pkg::time_t next_due;
  logic                  next_out_level;
  logic                  hit;
  time_stamp_pkg::time_t diff;

  assign cmd_ready = !pending;

  always_comb begin
    diff           = tb.now - due;
    hit            = pending && tb.valid && !diff[`TIME_WIDTH-1];
    next_pending   = pending;
    next_level_req = level_req;
    next_due       = due;
    next_out_level = out_level;
    if (hit) begin
      next_out_level = level_req;
      next_pending   = 1'b0;
    end
    if (cmd_valid && cmd_ready) begin
      next_pending   = 1'b1;
      next_level_req = cmd_level;
      next_due       = cmd_time;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pending   <= 1'b0;
      level_req <= 1'b0;
      due       <= 32'h0000_0000;
      out_level <= 1'b0;
      fired     <= 1'b0;
    end else begin
      pending   <= next_pending;
      level_req <= next_level_req;
      due       <= next_due;
      out_level <= next_out_level;
      fired     <= hit;
    end
  end
endmodule

// ===== network_time_stamp_unit.sv
// Network time stamp unit: local microsecond counter aligned to system time.
// Assumes cycle_start pulses once per bus cycle with master time on sys_time.
// What this block does
// - 32-bit microsecond counter wrapping freely
// - Initialise time from system time at startup
// - Latch controller time each system tick
// - Backplane reference point at cycle midpoint
// - Network reference is system minus cycle plus 20us
// - Store offset master time minus internal counter
// - Event time is counter plus stored offset
// - Capture network time at timestamp event
// - Timestamp rising, optional falling edges, interval
// - Drive output edges at commanded times
// - Capture measurement start and end times
`timescale 1ns/1ps
`include "time_stamp_regs.svh"
module network_time_stamp_unit #(
  parameter int CYCLES_PER_US = `CYCLES_PER_US,
  parameter int SOC_DELAY_US  = `NET_SOC_DELAY_US
) (
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire logic          startup,
  input  wire logic          cycle_start,
  input  time_stamp_pkg::time_source_t source,
  input  time_stamp_pkg::time_t sys_time,
  input  time_stamp_pkg::time_t bus_cycle_us,
  input  wire logic          sys_tick,
  input  wire logic          in_sig,
  input  wire logic          in_falling_enable,
  input  wire logic          out_cmd_valid,
  input  wire logic          out_cmd_level,
  input  time_stamp_pkg::time_t out_cmd_time,
  input  wire logic          meas_start,
  input  wire logic          meas_end,
  output logic               out_cmd_ready,
  output logic               out_sig,
  output logic               out_fired,
  output logic               in_event,
  output time_stamp_pkg::time_t in_rise_time,
  output time_stamp_pkg::time_t in_fall_time,
  output time_stamp_pkg::time_t in_interval,
  output time_stamp_pkg::time_t meas_start_time,
  output time_stamp_pkg::time_t meas_end_time,
  output logic               meas_done,
  output time_stamp_pkg::time_t latched_time,
  output time_stamp_pkg::time_t corrected_time,
  output logic               synced,
  output logic               cycle_short
);
  localparam int PRESC_W = $clog2(CYCLES_PER_US);

  time_base_if tb ();

  logic [PRESC_W-1:0]           presc;
  logic [PRESC_W-1:0]           next_presc;
  time_stamp_pkg::time_t        counter;
  time_stamp_pkg::time_t        next_counter;
  time_stamp_pkg::time_t        offset;
  time_stamp_pkg::time_t        next_offset;
  time_stamp_pkg::time_t        ref_time;
  time_stamp_pkg::time_t        next_latched_time;
  time_stamp_pkg::time_t        next_meas_start_time;
  time_stamp_pkg::time_t        next_meas_end_time;
  time_stamp_pkg::meas_state_t  meas_state;
  time_stamp_pkg::meas_state_t  next_meas_state;
  time_stamp_pkg::time_t        last_cycle;
  time_stamp_pkg::time_t        next_last_cycle;
  logic                         next_synced;
  logic                         next_cycle_short;
  logic                         us_tick;

  // Modular time difference
  function automatic time_stamp_pkg::time_t tdiff(input time_stamp_pkg::time_t a,
                                                  input time_stamp_pkg::time_t b);
    tdiff = a - b;
  endfunction

  // Reference point of the incoming master time
  always_comb begin
    case (source)
      time_stamp_pkg::SRC_BACKPLANE: ref_time = tdiff(sys_time, {1'b0, bus_cycle_us[31:1]});
      time_stamp_pkg::SRC_NETWORK:   ref_time = tdiff(sys_time, bus_cycle_us) + 32'(SOC_DELAY_US);
      default:                       ref_time = sys_time;
    endcase
  end

  // Time base and offset
  always_comb begin
    us_tick      = (presc == PRESC_W'(CYCLES_PER_US - 1));
    next_presc   = us_tick ? '0 : presc + 1'b1;
    next_counter = us_tick ? counter + 32'h0000_0001 : counter;
    next_offset  = offset;
    next_synced  = synced;
    next_last_cycle  = last_cycle;
    next_cycle_short = cycle_short;
    if (startup) begin
      next_offset     = tdiff(ref_time, counter);
      next_synced     = 1'b1;
      next_last_cycle = counter;
    end else if (cycle_start) begin
      next_offset      = tdiff(ref_time, counter);
      next_synced      = 1'b1;
      next_last_cycle  = counter;
      next_cycle_short = synced && (tdiff(counter, last_cycle) < 32'(`MIN_BUS_CYCLE_US));
    end
  end

  assign tb.now   = counter + offset;
  assign tb.valid = synced;

  // Latches, measurement capture
  always_comb begin
    next_latched_time    = sys_tick ? tb.now : latched_time;
    next_meas_state      = meas_state;
    next_meas_start_time = meas_start_time;
    next_meas_end_time   = meas_end_time;
    case (meas_state)
      time_stamp_pkg::MEAS_IDLE, time_stamp_pkg::MEAS_DONE: begin
        if (meas_start) begin
          next_meas_start_time = tb.now;
          next_meas_state      = time_stamp_pkg::MEAS_RUNNING;
        end
      end
      time_stamp_pkg::MEAS_RUNNING: begin
        if (meas_end) begin
          next_meas_end_time = tb.now;
          next_meas_state    = time_stamp_pkg::MEAS_DONE;
        end
      end
      default: next_meas_state = time_stamp_pkg::MEAS_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      presc           <= '0;
      counter         <= 32'h0000_0000;
      offset          <= 32'h0000_0000;
      synced          <= 1'b0;
      last_cycle      <= 32'h0000_0000;
      cycle_short     <= 1'b0;
      latched_time    <= 32'h0000_0000;
      corrected_time  <= 32'h0000_0000;
      meas_state      <= time_stamp_pkg::MEAS_IDLE;
      meas_start_time <= 32'h0000_0000;
      meas_end_time   <= 32'h0000_0000;
    end else begin
      presc           <= next_presc;
      counter         <= next_counter;
      offset          <= next_offset;
      synced          <= next_synced;
      last_cycle      <= next_last_cycle;
      cycle_short     <= next_cycle_short;
      latched_time    <= next_latched_time;
      corrected_time  <= tb.now;
      meas_state      <= next_meas_state;
      meas_start_time <= next_meas_start_time;
      meas_end_time   <= next_meas_end_time;
    end
  end

  assign meas_done = (meas_state == time_stamp_pkg::MEAS_DONE);

  edge_capture u_capture (
    .clk            (clk),
    .reset          (reset),
    .tb             (tb.sink),
    .sig_in         (in_sig),
    .falling_enable (in_falling_enable),
    .event_pulse    (in_event),
    .rise_time      (in_rise_time),
    .fall_time      (in_fall_time),
    .interval       (in_interval)
  );

  edge_scheduler u_sched (
    .clk       (clk),
    .reset     (reset),
    .tb        (tb.sink),
    .cmd_valid (out_cmd_valid),
    .cmd_level (out_cmd_level),
    .cmd_time  (out_cmd_time),
    .cmd_ready (out_cmd_ready),
    .out_level (out_sig),
    .fired     (out_fired)
  );
endmodule

// ===== nts_checker_asserts.sv
// Port assertions for the network time stamp unit.
// Assumes one clock domain; the prescaler parameter is passed through by the bind.
`timescale 1ns/1ps
module nts_checker #(
  parameter int CYCLES_PER_US = 200
) (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        startup,
  input wire logic        cycle_start,
  input wire logic        sys_tick,
  input wire logic        in_sig,
  input wire logic        out_cmd_valid,
  input wire logic        out_cmd_level,
  input wire logic        out_cmd_ready,
  input wire logic        out_sig,
  input wire logic        out_fired,
  input wire logic        in_event,
  input wire logic        meas_end,
  input wire logic        meas_done,
  input time_stamp_pkg::time_t latched_time,
  input time_stamp_pkg::time_t corrected_time,
  input wire logic        synced,
  input wire logic        cycle_short
);
  logic lvl;
  int   quiet;
  int   stall;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Commanded level, cycles since last sync, cycles without a time step
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lvl   <= 1'b0;
      quiet <= 0;
      stall <= 0;
    end else begin
      if (out_cmd_valid && out_cmd_ready) lvl <= out_cmd_level;
      quiet <= (cycle_start || startup) ? 0 : ((quiet < 1000) ? quiet + 1 : quiet);
      stall <= $changed(corrected_time) ? 0 : stall + 1;
    end
  end
  sequence s_sync;
    cycle_start || startup;
  endsequence
  sequence s_take;
    out_cmd_valid && out_cmd_ready;
  endsequence
  chk_sync_sets: assert property (s_sync |-> ##[1:2] synced)
    else $error("sync flag not set after time delivery");
  chk_cmd_taken: assert property (s_take |=> !out_cmd_ready)
    else $error("command not held pending");
  chk_fire_level: assert property (out_fired |-> out_sig == lvl && out_cmd_ready && synced)
    else $error("fired edge has wrong level");
  chk_out_hold: assert property (!out_fired |-> $stable(out_sig))
    else $error("output moved without a fired edge");
  chk_capture_gate: assert property (in_event |-> synced)
    else $error("capture before sync");
  chk_rise_event: assert property ($rose(in_sig) && synced |-> ##[1:2] in_event)
    else $error("rising edge not captured");
  chk_time_step: assert property (quiet > 3 |-> corrected_time - $past(corrected_time) <= 32'h1)
    else $error("time base jumped");
  chk_time_moves: assert property (synced && quiet > 3 |-> stall <= CYCLES_PER_US)
    else $error("time base stopped");
  chk_latch_tick: assert property (sys_tick && quiet > 3 |=> latched_time - $past(corrected_time) <= 32'h1)
    else $error("latched time wrong");
  chk_short_only: assert property ($changed(cycle_short) |-> $past(cycle_start || startup))
    else $error("cycle length flag moved between cycles");
  chk_meas_end: assert property ($rose(meas_done) |-> $past(meas_end))
    else $error("measurement done without end");
endmodule
bind network_time_stamp_unit nts_checker #(.CYCLES_PER_US(CYCLES_PER_US)) u_chk (
  .clk(clk), .reset(reset), .startup(startup), .cycle_start(cycle_start), .sys_tick(sys_tick),
  .in_sig(in_sig), .out_cmd_valid(out_cmd_valid), .out_cmd_level(out_cmd_level),
  .out_cmd_ready(out_cmd_ready), .out_sig(out_sig), .out_fired(out_fired), .in_event(in_event),
  .meas_end(meas_end), .meas_done(meas_done), .latched_time(latched_time),
  .corrected_time(corrected_time), .synced(synced), .cycle_short(cycle_short));

// ===== sys_time_master.sv
// Master model: keeps system time and sends it at each bus cycle start.
// Assumes the bench sets the cycle length; sys_time is valid only with cycle_start.
`timescale 1ns/1ps
module sys_time_master #(
  parameter int CPU = 2
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       run,
  input  time_stamp_pkg::time_t period_us,
  output logic            startup,
  output logic            cycle_start,
  output time_stamp_pkg::time_t sys_time
);
  time_stamp_pkg::time_t st;
  time_stamp_pkg::time_t cnt;
  int                    sub;
  logic                  first;
  logic                  due_now;
  assign due_now = run && (sub == CPU - 1) && (cnt >= period_us - 32'h1);
  always @(negedge clk or posedge reset) begin
    if (reset) begin
      st <= 32'hFFFF_F000;
      cnt <= 32'hFFFF_FFF0;
      sub <= 0;
      first <= 1'b1;
      startup <= 1'b0;
      cycle_start <= 1'b0;
      sys_time <= '0;
    end else begin
      cycle_start <= due_now;
      startup <= due_now && first;
      sys_time <= due_now ? st + 32'h1 : ~sys_time; // Released line toggles
      sub <= (sub == CPU - 1) ? 0 : sub + 1;
      if (due_now) first <= 1'b0;
      if (sub == CPU - 1) begin
        st <= st + 32'h1;
        cnt <= due_now ? 32'h0000_0000 : cnt + 32'h1;
      end
    end
  end
endmodule

// ===== network_time_stamp_unit_bench.sv
// Bench for the network time stamp unit against a behavioural time model.
// Assumes the master model supplies startup, cycle starts and system time.
`timescale 1ns/1ps
module network_time_stamp_unit_bench;
  localparam int CPU = 2;
  logic clk = 0, reset = 1, run = 0, sys_tick = 0, in_sig = 0, in_fe = 0, ov = 0, ol = 0, ms = 0, me = 0;
  logic startup, cycle_start, rdy, osig, fired, iev, mdone, synced, cshort;
  time_stamp_pkg::time_t sys_time, rt, ft, it, mst, met, lt, ct, t0, t1;
  time_stamp_pkg::time_t bc = 32'hFA, per = 32'hFA, ot = '0, m_now = '0;
  time_stamp_pkg::time_source_t src = time_stamp_pkg::SRC_NONE;
  int err_count = 0, n_checks = 0, seed = 93, m_sub = 0, cyc = 0, h;
  initial forever #2.5 clk = ~clk;
  sys_time_master #(.CPU(CPU)) partner (.clk(clk), .reset(reset), .run(run), .period_us(per),
    .startup(startup), .cycle_start(cycle_start), .sys_time(sys_time));
  network_time_stamp_unit #(.CYCLES_PER_US(CPU)) DUT (.clk(clk), .reset(reset), .startup(startup),
    .cycle_start(cycle_start), .source(src), .sys_time(sys_time), .bus_cycle_us(bc), .sys_tick(sys_tick),
    .in_sig(in_sig), .in_falling_enable(in_fe), .out_cmd_valid(ov), .out_cmd_level(ol), .out_cmd_time(ot),
    .meas_start(ms), .meas_end(me), .out_cmd_ready(rdy), .out_sig(osig), .out_fired(fired), .in_event(iev),
    .in_rise_time(rt), .in_fall_time(ft), .in_interval(it), .meas_start_time(mst), .meas_end_time(met),
    .meas_done(mdone), .latched_time(lt), .corrected_time(ct), .synced(synced), .cycle_short(cshort));
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk_t(input time_stamp_pkg::time_t got, input time_stamp_pkg::time_t exp, input int tol);
    n_checks++;
    if ($signed(got - exp) <= tol && $signed(exp - got) <= tol) begin
    end else begin
      err_count++;
      $display("[FAIL] %0t time %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Model time: reference at each delivery, then one step per microsecond
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (startup || cycle_start) begin
      m_sub <= 0;
      case (src)
        time_stamp_pkg::SRC_BACKPLANE: m_now <= sys_time - (bc >> 1);
        time_stamp_pkg::SRC_NETWORK: m_now <= sys_time - bc + 32'h14;
        default: m_now <= sys_time;
      endcase
    end else if (m_sub == CPU - 1) begin
      m_sub <= 0;
      m_now <= m_now + 32'h1;
    end else m_sub <= m_sub + 1;
    if (cyc > 40000) begin
      err_count++;
      end_sim();
    end
  end
  initial begin
    tick(4);
    reset = 0;
    tick(2);
    chk_b(rdy, 1'b1);
    chk_b(synced, 1'b0);
    in_sig = 1;
    tick(3);
    chk_b(iev, 1'b0);
    in_sig = 0;
    $display("test reset done");
    run = 1;
    in_fe = 1;
    for (int s = 0; s < 3; s++) begin
      src = time_stamp_pkg::time_source_t'(s);
      bc = 32'hC8 + ($random(seed) & 32'h7F);
      per = bc;
      repeat (2) @(posedge cycle_start);
      tick(6);
      chk_t(ct, m_now, 2);
      chk_b(synced, 1'b1);
      sys_tick = 1;
      tick(1);
      sys_tick = 0;
      t0 = m_now;
      tick(1);
      chk_t(lt, t0, 2);
    end
    $display("test sync done");
    repeat (2) begin
      h = 5 + ($random(seed) & 15);
      in_sig = 1;
      t0 = m_now;
      wait (iev === 1'b1);
      #1 chk_t(rt, t0, 2);
      tick(h * CPU);
      in_sig = 0;
      t0 = m_now;
      wait (iev === 1'b1);
      #1 chk_t(ft, t0, 2);
      chk_t(it, 32'(h), 2);
      tick(3);
    end
    in_fe = 0;
    in_sig = 1;
    tick(2);
    in_sig = 0;
    t1 = ft;
    tick(1);
    chk_b(iev, 1'b0);
    chk_t(ft, t1, 0);
    $display("test capture done");
    for (int l = 1; l >= 0; l--) begin
      ot = m_now + bc + ($random(seed) & 32'h3F);
      ol = l[0];
      ov = 1;
      tick(1);
      ov = 0;
      chk_b(rdy, 1'b0);
      wait (fired === 1'b1);
      #1 chk_t(m_now, ot, 2);
      chk_b(osig, l[0]);
      tick(2);
    end
    $display("test output done");
    ms = 1;
    t0 = m_now;
    tick(1);
    ms = 0;
    tick(20 * CPU);
    me = 1;
    t1 = m_now;
    tick(1);
    me = 0;
    tick(2);
    chk_b(mdone, 1'b1);
    chk_t(mst, t0, 2);
    chk_t(met, t1, 2);
    $display("test measure done");
    per = 32'h32;
    repeat (3) @(posedge cycle_start);
    tick(2);
    chk_b(cshort, 1'b1);
    per = 32'hFA;
    repeat (2) @(posedge cycle_start);
    tick(2);
    chk_b(cshort, 1'b0);
    $display("test cycle length done");
    end_sim();
  end
endmodule
